// ==== rtl/pm_seq_map.svh ====
// constants of the reset and power management sequencer
`ifndef PM_SEQ_MAP_SVH
`define PM_SEQ_MAP_SVH

// configuration space byte addresses
`define CMD_REG_ADDR 8'h04
`define PM_CAP_PTR 8'hdc
`define PM_CAP_OFS 8'h00
`define PM_CSR_OFS 8'h04

// fields of the command register
`define CMD_IO_EN_BIT 0
`define CMD_MEM_EN_BIT 1

// fields of the capability word
`define CAP_ID_VALUE 8'h01
`define CAP_NEXT_VALUE 8'he4
`define PME_SUPPORT_NO_AUX 5'h09
`define PME_SUPPORT_AUX 5'h19
`define PMC_LOW_DEFAULT 11'h022

// fields of the control / status word
`define CSR_PSTATE_LSB 0
`define CSR_WAKE_EN_BIT 8
`define CSR_WAKE_STS_BIT 15

// power state output values
`define PWR_OUT_RESET 2'h0
`define PWR_OUT_ACTIVE 2'h3

// clock settling after bus reset release
`define SETTLE_CLKS 512
`define SETTLE_WAIT_MAX 520

`endif

// ==== rtl/pm_seq_pkg.sv ====
// types shared by the reset and power management sequencer
package pm_seq_pkg;

  // sequence states, gray coded along reset -> settle -> d0u -> d0
  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_SETTLE = 2'h1,
    ST_D0U = 2'h3,
    ST_D0A = 2'h2
  } seq_state_t;

  // two-bit power state field encoding
  typedef logic [1:0] pstate_t;

endpackage : pm_seq_pkg

// ==== rtl/settle_timer.sv ====
// clock settling timer started on bus reset release
`timescale 1ns/1ps
`include "pm_seq_map.svh"
module settle_timer #(
  parameter int unsigned count_cycles = `SETTLE_CLKS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  output logic done
);
  import pm_seq_pkg::*;

  localparam int unsigned CW = $clog2(count_cycles + 1);
  localparam logic [CW-1:0] LOAD = CW'(count_cycles - 1);

  // whole timer state
  typedef struct packed {
    logic [CW-1:0] cnt; // cycles still to wait
    logic busy;         // counting
    logic done;         // one-cycle completion pulse
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////
  // next state: abort wins, so a new bus reset never leaves a stale pulse
  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    if (abort) begin
      nxt_state.busy = 1'b0;
      nxt_state.cnt = '0;
    end else if (start) begin
      nxt_state.busy = 1'b1;
      nxt_state.cnt = LOAD;
    end else if (state_ff.busy) begin
      if (state_ff.cnt == '0) begin
        nxt_state.busy = 1'b0;
        nxt_state.done = 1'b1;
      end else begin
        nxt_state.cnt = state_ff.cnt - CW'(1);
      end
    end
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign done = state_ff.done;

endmodule : settle_timer

// ==== rtl/pm_reset_sequencer.sv ====
// bus reset sequencing and power management capability registers
`timescale 1ns/1ps
`include "pm_seq_map.svh"
module pm_reset_sequencer #(
  parameter int unsigned settle_cycles = `SETTLE_CLKS,
  parameter logic [10:0] pmc_low = `PMC_LOW_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pci_rst_n,
  input wire logic lan_power_good_reset,
  input wire logic aux_power,
  input wire logic legacy_wakeup,
  input wire logic clkrun_enable,
  input wire logic wake_event,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  output logic pci_pins_oe_n,
  output logic pme_out,
  output logic pme_oe_n,
  output logic clkrun_req,
  output logic nvm_reload,
  output logic [1:0] power_state_outputs,
  output pm_seq_pkg::seq_state_t seq_state
);
  import pm_seq_pkg::*;

  // whole block state
  typedef struct packed {
    seq_state_t fsm;          // reset sequence position
    logic rst_q;              // bus reset level one cycle ago
    pstate_t pstate;          // power state field
    logic wake_event_enable;  // wake enable field
    logic wake_event_status;  // wake status field
    logic [1:0] pwr_out;      // power state outputs
    logic oe_n;               // bus pins released when high
    logic pme_oe_n;           // wake pin pulled low when low
    logic clkrun;             // clock wanted during settling
    logic reload;             // nvm reload pulse
    logic ack;                // config access answer
    logic [31:0] rdata;       // config read data
  } seq_reg_t;

  seq_reg_t state_ff;
  seq_reg_t nxt_state;
  logic settle_done;
  logic rise;
  logic ready;
  logic cmd_en_wr;

  ////////////////////////////////////////////////////////////////////////
  // address helpers, offsets taken from the capability pointer
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == 8'(`PM_CAP_PTR + ofs));
  endfunction : hit

  // capability word as read by the host
  function automatic logic [31:0] cap_word(input logic aux);
    logic [4:0] sup;
    sup = aux ? `PME_SUPPORT_AUX : `PME_SUPPORT_NO_AUX;
    cap_word = {sup, pmc_low, `CAP_NEXT_VALUE, `CAP_ID_VALUE};
  endfunction : cap_word

  ////////////////////////////////////////////////////////////////////////
  // settle timer, restarted on every reset release
  settle_timer #(
    .count_cycles(settle_cycles)
  ) u_settle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(rise),
    .abort(!pci_rst_n),
    .done(settle_done)
  );

  // decode of events seen this cycle
  always_comb begin
    rise = pci_rst_n && !state_ff.rst_q;
    ready = pci_rst_n && (state_ff.fsm == ST_D0U || state_ff.fsm == ST_D0A);
    cmd_en_wr = ready && cfg_wr && cfg_be[0] && cfg_addr == `CMD_REG_ADDR &&
      (cfg_wdata[`CMD_MEM_EN_BIT] || cfg_wdata[`CMD_IO_EN_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rst_q = pci_rst_n;
    nxt_state.reload = 1'b0;
    nxt_state.ack = 1'b0;
    // sequence; bus reset dominates every state
    if (!pci_rst_n) begin
      nxt_state.fsm = ST_RESET;
      nxt_state.oe_n = 1'b1;
      nxt_state.pwr_out = `PWR_OUT_RESET;
      nxt_state.clkrun = 1'b0;
    end else begin
      case (state_ff.fsm)
        ST_RESET: begin
          if (rise) begin
            nxt_state.fsm = ST_SETTLE;
            nxt_state.reload = 1'b1;
          end
        end
        ST_SETTLE: begin
          // pins stay released while clocks settle
          nxt_state.clkrun = clkrun_enable;
          if (settle_done) begin
            nxt_state.fsm = ST_D0U;
            nxt_state.oe_n = 1'b0;
            nxt_state.clkrun = 1'b0;
            nxt_state.pwr_out = {1'b0, legacy_wakeup};
          end
        end
        ST_D0U: begin
          if (cmd_en_wr) begin
            nxt_state.fsm = ST_D0A;
            nxt_state.pwr_out = `PWR_OUT_ACTIVE;
          end
        end
        ST_D0A: begin
          // active; leaves only through bus reset
        end
        default: begin
          nxt_state.fsm = ST_RESET;
        end
      endcase
    end
    // config accesses answered only once settled
    if (ready && (cfg_rd || cfg_wr)) begin
      nxt_state.ack = 1'b1;
      nxt_state.rdata = '0;
      if (cfg_rd && hit(cfg_addr, `PM_CAP_OFS)) begin
        nxt_state.rdata = cap_word(aux_power);
      end else if (cfg_rd && hit(cfg_addr, `PM_CSR_OFS)) begin
        nxt_state.rdata[`CSR_PSTATE_LSB +: 2] = state_ff.pstate;
        nxt_state.rdata[`CSR_WAKE_EN_BIT] = state_ff.wake_event_enable;
        nxt_state.rdata[`CSR_WAKE_STS_BIT] = state_ff.wake_event_status;
      end
      // only the control / status word takes writes
      if (cfg_wr && hit(cfg_addr, `PM_CSR_OFS)) begin
        if (cfg_be[0]) begin
          nxt_state.pstate = cfg_wdata[`CSR_PSTATE_LSB +: 2];
        end
        if (cfg_be[1]) begin
          nxt_state.wake_event_enable = cfg_wdata[`CSR_WAKE_EN_BIT];
          if (cfg_wdata[`CSR_WAKE_STS_BIT]) begin
            nxt_state.wake_event_status = 1'b0;
          end
        end
      end
    end
    // field resets on reset release
    if (rise) begin
      nxt_state.pstate = '0;
      if (!aux_power) begin
        nxt_state.wake_event_enable = 1'b0;
        nxt_state.wake_event_status = 1'b0;
      end
    end
    // a wake event beats a host or release clear in the same cycle, but not a lan reset
    if (wake_event) begin
      nxt_state.wake_event_status = 1'b1;
    end
    // lan power good returns every field to default
    if (lan_power_good_reset) begin
      nxt_state.pstate = '0;
      nxt_state.wake_event_enable = 1'b0;
      nxt_state.wake_event_status = 1'b0;
    end
    // wake pin is held through bus reset; a release without aux power floats it
    nxt_state.pme_oe_n =
      !(nxt_state.wake_event_enable && nxt_state.wake_event_status);
  end

  // register the state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= '0;
      state_ff.oe_n <= 1'b1;
      state_ff.pme_oe_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops, except pme_out tied low
  assign cfg_rdata = state_ff.rdata;
  assign cfg_ack = state_ff.ack;
  assign pci_pins_oe_n = state_ff.oe_n;
  assign pme_out = 1'b0; // open drain, only pulls low
  assign pme_oe_n = state_ff.pme_oe_n;
  assign clkrun_req = state_ff.clkrun;
  assign nvm_reload = state_ff.reload;
  assign power_state_outputs = state_ff.pwr_out;
  assign seq_state = state_ff.fsm;

  ////////////////////////////////////////////////////////////////////////
  // checks
  localparam int WAIT_MAX = `SETTLE_WAIT_MAX;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_reset_floats: assert property (
    !pci_rst_n |=> pci_pins_oe_n && seq_state == ST_RESET && !cfg_ack)
    else $error("bus pins not floated in reset");
  a_release_reload: assert property (
    $rose(pci_rst_n) |=> nvm_reload ##1 !nvm_reload)
    else $error("no nvm reload on reset release");
  a_settle_quiet: assert property (
    $rose(pci_rst_n) |=> (pci_pins_oe_n && !cfg_ack) [*8])
    else $error("device active while settling");
  a_settle_ends: assert property (
    $rose(pci_rst_n) |-> ##[1:WAIT_MAX] (!pci_rst_n || seq_state == ST_D0U))
    else $error("settling never ends");
  a_pwr_after_settle: assert property (
    seq_state == ST_SETTLE ##1 seq_state == ST_D0U |->
      power_state_outputs == {1'b0, $past(legacy_wakeup)})
    else $error("wrong power outputs after reset");
  a_enable_d0: assert property (
    cmd_en_wr && seq_state == ST_D0U |=> seq_state == ST_D0A)
    else $error("access enable did not reach d0");
  a_enable_pwr: assert property (
    cmd_en_wr && seq_state == ST_D0U |=> power_state_outputs == 2'h3)
    else $error("power outputs not high in d0");
  a_lan_reset: assert property (
    lan_power_good_reset |=> state_ff.pstate == 2'h0 &&
      !state_ff.wake_event_enable && !state_ff.wake_event_status)
    else $error("lan reset left a field set");
  a_rise_pstate: assert property (
    $rose(pci_rst_n) |=> state_ff.pstate == 2'h0)
    else $error("power state kept over reset");
  a_aux_keeps: assert property (
    $rose(pci_rst_n) && aux_power && !lan_power_good_reset |=>
      state_ff.wake_event_enable == $past(state_ff.wake_event_enable))
    else $error("wake enable lost with aux power");
  a_cap_read: assert property (
    ready && cfg_rd && hit(cfg_addr, `PM_CAP_OFS) |=>
      cfg_ack && cfg_rdata[15:0] == 16'he401)
    else $error("pm_capability_identifier or pointer wrong");
  a_ro_write: assert property (
    ready && cfg_wr |=> cfg_ack)
    else $error("config write not completed");

  c_reach_d0: cover property (seq_state == ST_D0U ##[1:20] seq_state == ST_D0A);
  c_wake_pin: cover property ($fell(pme_oe_n));
  c_reset_mid: cover property (seq_state == ST_SETTLE ##1 !pci_rst_n);
  c_cap_read: cover property (cfg_ack && cfg_rdata[7:0] == 8'h01);

endmodule : pm_reset_sequencer

// ==== sim/pci_host_model.sv ====
// host side model: owns the bus reset pin, runs from the bench clock
`timescale 1ns/1ps
module pci_host_model (
  input wire logic ref_clk,
  input wire logic rst_req,
  output logic pci_rst_n
);
  ////////////////////////////////////////////////////////////////////////
  // reset pin follows the request one edge later; the clock never stops,
  // so reset always leads any pause and clock-run requests are served
  always_ff @(posedge ref_clk) begin
    pci_rst_n <= ~rst_req;
  end
endmodule : pci_host_model

// ==== sim/pci_reset_power_mgmt_sequencer_bench.sv ====
// self-checking bench for the reset and power management sequencer
`timescale 1ns/1ps
module pci_reset_power_mgmt_sequencer_bench;
  import pm_seq_pkg::*;
  localparam int unsigned settle_n = 8; // short settling, keeps run brief
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_req = 1'b1;
  logic pci_rst_n;
  logic lan_power_good_reset = 1'b0;
  logic aux_power = 1'b0;
  logic legacy_wakeup = 1'b0;
  logic clkrun_enable = 1'b1;
  logic wake_event = 1'b0;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] cfg_rdata;
  logic cfg_ack, pci_pins_oe_n, pme_out, pme_oe_n, clkrun_req, nvm_reload;
  logic [1:0] power_state_outputs;
  seq_state_t seq_state;
  int n_mismatch = 0;
  int n_compared = 0;
  // capability word as it must always read, no aux power
  localparam logic [31:0] cap_word = {5'h09, 11'h022, 8'he4, 8'h01};

  always #20 ref_clk = ~ref_clk;

  pci_host_model host_u (.ref_clk(ref_clk), .rst_req(rst_req),
    .pci_rst_n(pci_rst_n));

  pm_reset_sequencer #(.settle_cycles(settle_n)) dut_u (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .pci_rst_n(pci_rst_n),
    .lan_power_good_reset(lan_power_good_reset), .aux_power(aux_power),
    .legacy_wakeup(legacy_wakeup), .clkrun_enable(clkrun_enable),
    .wake_event(wake_event), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .pci_pins_oe_n(pci_pins_oe_n), .pme_out(pme_out), .pme_oe_n(pme_oe_n),
    .clkrun_req(clkrun_req), .nvm_reload(nvm_reload),
    .power_state_outputs(power_state_outputs), .seq_state(seq_state));

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one config request, held one edge, answer sampled after the next
  task automatic cfg(input logic rd, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d, output logic ack,
      output logic [31:0] q);
    @(posedge ref_clk);
    cfg_rd <= rd;
    cfg_wr <= ~rd;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    #1;
    ack = cfg_ack;
    q = cfg_rdata;
  endtask : cfg

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic ack;
    logic [31:0] q;
    cfg(1'b1, a, 4'hf, 32'h0, ack, q);
    check(ack, 1'b1);
    check(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
    logic ack;
    logic [31:0] q;
    cfg(1'b0, a, be, d, ack, q);
    check(ack, 1'b1);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////
  // full bus reset; requests during reset and settling must go unanswered
  task automatic bus_reset(input logic aux, input logic leg, input logic cr);
    int n;
    logic ack;
    logic [31:0] q;
    @(posedge ref_clk);
    aux_power <= aux;
    legacy_wakeup <= leg;
    clkrun_enable <= cr;
    rst_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(seq_state, ST_RESET);
    check(pci_pins_oe_n, 1'b1);
    check(power_state_outputs, 2'h0);
    cfg(1'b1, 8'hdc, 4'hf, 32'h0, ack, q);
    check(ack, 1'b0);
    @(posedge ref_clk);
    rst_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(nvm_reload, 1'b1);
    cfg(1'b1, 8'hdc, 4'hf, 32'h0, ack, q);
    check(ack, 1'b0);
    check(clkrun_req, cr);
    n = 0;
    // pins must stay floated for the rest of the settling span, after the settling read
    while (seq_state !== ST_D0U && n < 600) begin
      if (pci_pins_oe_n !== 1'b1) check(pci_pins_oe_n, 1'b1);
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n + 2 >= settle_n && n <= settle_n + 2, 1'b1);
    check(pci_pins_oe_n, 1'b0);
    check(power_state_outputs, {1'b0, leg});
  endtask : bus_reset

  // access enable moves d0u to d0 and raises both power outputs
  task automatic sc_enable(input logic [31:0] d);
    check(seq_state, ST_D0U);
    wr(8'h04, 4'h1, d);
    check(seq_state, ST_D0A);
    check(power_state_outputs, 2'h3);
  endtask : sc_enable

  // read-only capability bytes ignore writes
  task automatic sc_cap();
    rd(8'hdc, cap_word);
    wr(8'hdc, 4'hf, 32'hffff_ffff);
    rd(8'hdc, cap_word);
  endtask : sc_cap

  // wake bits across bus resets with and without aux power, then lan reset
  task automatic sc_wake();
    wr(8'he0, 4'h3, 32'h0000_0103);
    rd(8'he0, 32'h0000_0103);
    @(posedge ref_clk);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(pme_oe_n, 1'b0);
    check(pme_out, 1'b0);
    bus_reset(1'b1, 1'b0, 1'b0);
    rd(8'he0, 32'h0000_8100);
    check(pme_oe_n, 1'b0);
    bus_reset(1'b0, 1'b0, 1'b1);
    rd(8'he0, 32'h0000_0000);
    sc_enable(32'h1);
    wr(8'he0, 4'h2, 32'h0000_0100);
    @(posedge ref_clk);
    lan_power_good_reset <= 1'b1;
    @(posedge ref_clk);
    lan_power_good_reset <= 1'b0;
    rd(8'he0, 32'h0000_0000);
  endtask : sc_wake

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // main sequence; host holds reset through the design's own reset
  initial begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus_reset(1'b0, 1'b1, 1'b1);
    sc_cap();
    // host lingers in d0u before enabling access
    repeat (20) @(posedge ref_clk);
    sc_enable(32'h2);
    sc_wake();
    stop_test();
  end

  // whole run is just over a hundred cycles; this cuts a hang short
  initial begin
    #(40 * 3000);
    n_mismatch++;
    stop_test();
  end
endmodule : pci_reset_power_mgmt_sequencer_bench
